/* File: dv/fcml_loader_assertions.sv */
// Port-level checks on the configuration mode loader
`timescale 1ns/1ps
module fcml_loader_chk (
  // Clock, reset, controls
  input wire        clk_i,
  input wire        reset_i,
  input wire [1:0]  readback_opt_i,
  input wire        readback_trigger_pin_i,
  // Observed outputs
  input wire        config_clock_o,
  input wire        config_clock_oe_o,
  input wire [15:0] addr_o,
  input wire        read_clock_o,
  input wire        ready_o,
  input wire        readback_data_pin_o,
  input wire        readback_data_oe_o,
  input wire        done_o
);
  reg       cc_q;
  reg       have_q;
  reg [3:0] rc_q;
  reg [3:0] bu_q;
  wire      rise = config_clock_o & ~cc_q;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cc_q   <= 1'b0;
      have_q <= 1'b0;
      rc_q   <= 4'h0;
      bu_q   <= 4'h0;
    end else begin
      cc_q   <= config_clock_o;
      have_q <= have_q | read_clock_o;
      rc_q   <= read_clock_o ? 4'h0 : rc_q + {3'h0, rise};
      bu_q   <= ready_o ? 4'h0 : bu_q + {3'h0, rise};
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_high8;
    config_clock_o [*8] ##1 !config_clock_o;
  endsequence
  sequence s_rb_go;
    $past(done_o) && readback_trigger_pin_i && readback_data_pin_o;
  endsequence
  property p_half;
    $rose(config_clock_o) |-> s_high8;
  endproperty
  a_half: assert property (p_half) else $error("clock phase");
  property p_byte;
    read_clock_o && have_q |-> rc_q + rise == 4'h8;
  endproperty
  a_byte: assert property (p_byte) else $error("byte rate");
  property p_step;
    $changed(addr_o) |-> addr_o - $past(addr_o) == 16'h0001 ||
      $past(addr_o) - addr_o == 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("addr step");
  property p_burst;
    $rose(ready_o) && bu_q != 4'h0 |-> bu_q == 4'h8;
  endproperty
  a_burst: assert property (p_burst) else $error("burst");
  property p_never;
    readback_opt_i[0] == readback_opt_i[1] |-> !readback_data_oe_o;
  endproperty
  a_never: assert property (p_never) else $error("rb never");
  property p_rbin;
    $rose(readback_data_oe_o) |-> s_rb_go;
  endproperty
  a_rbin: assert property (p_rbin) else $error("rb start");
  property p_rbout;
    $fell(readback_data_oe_o) |-> readback_data_pin_o && done_o;
  endproperty
  a_rbout: assert property (p_rbout) else $error("rb end");
  property p_oe;
    readback_data_oe_o |-> !config_clock_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("clock pin");
endmodule
bind fcml_loader fcml_loader_chk fcml_loader_chk_i (
  .clk_i(clk_i), .reset_i(reset_i), .readback_opt_i(readback_opt_i),
  .readback_trigger_pin_i(readback_trigger_pin_i),
  .config_clock_o(config_clock_o), .config_clock_oe_o(config_clock_oe_o),
  .addr_o(addr_o), .read_clock_o(read_clock_o), .ready_o(ready_o),
  .readback_data_pin_o(readback_data_pin_o),
  .readback_data_oe_o(readback_data_oe_o), .done_o(done_o));

/* File: dv/fcml_loader_test.sv */
// Self-checking bench for the configuration mode loader
`timescale 1ns/1ps
`include "fcml_loader_map.vh"
module fcml_loader_test;
  reg          clk_i = 1'b0;
  reg          reset_i = 1'b1;
  reg          start_i = 1'b0;
  reg  [2:0]   mode_i = 3'h0;
  reg          cmos_i = 1'b0;
  reg          pull_i = 1'b0;
  reg  [1:0]   opt_i = 2'h0;
  reg  [3:0]   st_i = 4'h0;
  reg          lk_i = 1'b0;
  reg          ws_n = 1'b1;
  reg          csa_n = 1'b1;
  reg          csb_n = 1'b1;
  reg          csc = 1'b0;
  reg          trig = 1'b0;
  reg  [7:0]   pd = 8'h00;
  reg  [2:0]   lat = 3'h0;
  wire         cc_o, cc_oe, dout, rclk, ready, rb_d, rb_oe, done;
  wire         io_cmos, fx_cmos, io_pu, din;
  wire [15:0]  addr;
  wire [7:0]   prom_d;
  wire [7:0]   dat = mode_i == `FCML_MODE_PER ? pd : prom_d;
  integer      fails = 0;
  integer      checks_done = 0;
  integer      cyc = 0;
  integer      nr = 0;
  integer      t, i;
  reg  [31:0]  r;
  reg  [15:0]  ad_q = 16'h0000;
  reg          cc_q = 1'b0;
  reg          rdy_q = 1'b0;
  reg          sb [0:127];
  reg  [7:0]   fw [0:3];
  logic [15:0] q_a [$];
  logic [3:0]  q_b [$];
  logic        q_r [$];
  fcml_loader fcml_loader_i (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(start_i), .mode_i(mode_i), .cmos_opt_i(cmos_i),
    .pullup_opt_i(pull_i), .readback_opt_i(opt_i), .state_bits_i(st_i),
    .din_i(din), .config_clock_i(lk_i), .config_clock_o(cc_o),
    .config_clock_oe_o(cc_oe), .dout_o(dout), .addr_o(addr),
    .read_clock_o(rclk), .data_i(dat), .write_strobe_n_i(ws_n),
    .chip_select_a_n_i(csa_n), .chip_select_b_n_i(csb_n),
    .chip_select_c_high_i(csc), .ready_o(ready),
    .readback_trigger_pin_i(trig), .readback_data_pin_o(rb_d),
    .readback_data_oe_o(rb_oe), .done_o(done), .io_cmos_o(io_cmos),
    .fixed_cmos_o(fx_cmos), .io_pullup_o(io_pu));
  fcml_prom fcml_prom_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr),
    .high_i(mode_i == `FCML_MODE_PHI), .lat_i(lat), .data_o(prom_d),
    .sclk_i(mode_i == `FCML_MODE_SLV ? lk_i : cc_o), .din_o(din));
  always #20 clk_i = ~clk_i;
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wt(input integer sel, input integer lim);
    integer n;
    begin
      n = 0;
      while ((sel ? done : ready) !== 1'b1 && n < lim) begin
        @(posedge clk_i);
        n = n + 1;
      end
    end
  endtask
  // Header, four random frames with three stop bits, length 88
  task build;
    integer k, j;
    reg [27:0] hd;
    begin
      hd = {`FCML_PRE_CODE, 24'd88};
      for (k = 0; k < 128; k = k + 1)
        sb[k] = k >= 8 && k < 36 ? hd[35 - k] : 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        r = $urandom;
        fw[k] = r[7:0];
        sb[36 + 12 * k] = 1'b0;
        for (j = 0; j < 8; j = j + 1)
          sb[37 + 12 * k + j] = r[j];
      end
      for (k = 0; k < 128; k = k + 1)
        fcml_prom_i.mem[k / 8][k % 8] = sb[k];
    end
  endtask
  task pwr(input [3:0] act, input [7:0] d);
    begin
      @(posedge clk_i);
      {ws_n, csa_n, csb_n, csc} <= act ^ 4'he;
      pd <= d;
      repeat (4) @(posedge clk_i);
      {ws_n, csa_n, csb_n, csc} <= 4'he;
      pd <= ~d;
    end
  endtask
  task rb(input logic on);
    integer f, j;
    begin
      if (on) begin
        q_r.push_back(1'b1);
        q_r.push_back(1'b1);
        for (f = 0; f < 4; f = f + 1) begin
          q_r.push_back(1'b0);
          for (j = 0; j < 8; j = j + 1)
            q_r.push_back(j == 7 ? ~st_i[f] : ~fw[f][j]);
          q_r.push_back(1'b1);
        end
      end
      @(posedge clk_i) trig <= 1'b1;
      repeat (8) @(posedge clk_i);
      #17;
      repeat (44) begin
        lk_i = 1'b1;
        #160 lk_i = 1'b0;
        #160;
      end
      @(posedge clk_i) trig <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("rb_left", 16'(q_r.size()), 0);
      chk("rb_oe", rb_oe, 0);
    end
  endtask
  always @(negedge lk_i)
    if (rb_oe === 1'b1) begin
      if (q_r.size() == 0)
        chk("rb_extra", 1, 0);
      else
        chk("rb_bit", rb_d, q_r.pop_front());
    end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      close_out;
    end
    if (reset_i === 1'b0 && addr !== ad_q && q_a.size() != 0)
      chk("addr", addr, q_a.pop_front());
    if (cc_o === 1'b1 && cc_q === 1'b0)
      nr = nr + 1;
    if (ready === 1'b0 && rdy_q === 1'b1)
      nr = 0;
    if (ready === 1'b1 && rdy_q === 1'b0 && q_b.size() != 0)
      chk("burst", 16'(nr), q_b.pop_front());
    ad_q = addr;
    cc_q = cc_o;
    rdy_q = ready;
  end
  initial begin
    r = $urandom(32'h7795a57c);
    for (t = 0; t < 5; t = t + 1) begin
      @(posedge clk_i);
      r = $urandom;
      reset_i <= 1'b1;
      mode_i <= t == 0 ? `FCML_MODE_PLO : t == 1 ? `FCML_MODE_PHI :
        t == 2 ? `FCML_MODE_SER : t == 3 ? `FCML_MODE_PER : `FCML_MODE_SLV;
      opt_i <= t > 1 ? `FCML_RB_CMD : t[1:0];
      {cmos_i, pull_i, lat, st_i} <= r[8:0];
      build;
      q_a.delete();
      for (i = 0; i < 15; i = i + 1)
        if (t < 2)
          q_a.push_back(t ? 16'hffff - 16'(i) : 16'(i + 1));
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      chk("idle", {ready, done, rb_oe, cc_oe, fx_cmos, io_pu}, 3);
      @(posedge clk_i) start_i <= 1'b1;
      @(posedge clk_i) start_i <= 1'b0;
      // Slave load from an external clock, 320 ns period
      if (t == 4)
        repeat (100) begin
          lk_i <= 1'b1;
          repeat (4) @(posedge clk_i);
          lk_i <= 1'b0;
          repeat (4) @(posedge clk_i);
        end
      if (t == 3)
        for (i = 0; i < 11; i = i + 1) begin
          wt(0, 400);
          chk("ready", ready, 1);
          r = $urandom;
          pwr(4'hf ^ (4'h1 << r[1:0]), 8'h00);
          repeat (6) @(posedge clk_i);
          chk("ignored", ready, 1);
          q_b.push_back(4'h8);
          pwr(4'hf, fcml_prom_i.mem[i]);
          repeat (4) @(posedge clk_i);
          chk("busy", ready, 0);
        end
      wt(1, 4000);
      repeat (3) @(posedge clk_i);
      chk("done", {done, io_cmos, io_pu}, {1'b1, cmos_i, pull_i});
      chk("dout", dout, 1);
      chk("bytes", q_a.size() < 6, 1);
      rb(opt_i != `FCML_RB_NEVER);
      rb(opt_i == `FCML_RB_CMD);
      $display("test %0d done", t);
    end
    close_out;
  end
endmodule

/* File: dv/fcml_prom.sv */
// Byte memory and serial source on the loader's far side
`timescale 1ns/1ps
module fcml_prom (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // Byte port with answer delay
  input  wire [15:0] addr_i,
  input  wire        high_i,
  input  wire [2:0]  lat_i,
  output reg  [7:0]  data_o,
  // Serial port
  input  wire        sclk_i,
  output wire        din_o
);
  reg  [7:0]  mem [0:15];
  reg  [15:0] ad_q;
  reg  [2:0]  wait_q;
  reg  [6:0]  bit_q;
  reg         sc_q;
  wire [15:0] off = high_i ? ~addr_i : addr_i;
  assign din_o = mem[bit_q[6:3]][bit_q[2:0]];
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ad_q   <= 16'h0000;
      wait_q <= 3'h0;
      bit_q  <= 7'h00;
      sc_q   <= 1'b0;
      data_o <= 8'h00;
    end else begin
      ad_q <= addr_i;
      sc_q <= sclk_i;
      // Next bit only after the falling edge
      if (sc_q && !sclk_i)
        bit_q <= bit_q + 7'h01;
      // Bus shows garbage while the slow answer is pending
      if (addr_i != ad_q) begin
        wait_q <= lat_i;
        data_o <= ~data_o;
      end else if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
      else
        data_o <= off[15:4] == 12'h000 ? mem[off[3:0]] : 8'hff;
    end
  end
endmodule

/* File: src/fcml_loader.v */
// Configuration mode loader: master, peripheral, slave, chain, readback
// Behaviour
// - Parallel low starts address 0000 upward; parallel high FFFF downward.
// - Parallel modes drive 16-bit address and capture the returned byte.
// - Byte bits serialise from D0; next byte's D0 follows previous bit.
// - Master modes make the clock internally; serial master samples data in.
// - Peripheral write needs strobe and all three selects active together.
// - Each qualified peripheral write while ready is high captures one byte into a buffer.
// - Ready goes high once the buffered byte is used up.
// - Peripheral mode sends eight clock pulses per write, serialising the byte.
// - Parallel master clock runs at eight times the address rate.
// - Slave samples data on rising clock, shifts data out on falling.
// - Lead passes preamble and length, then holds data out high.
// - After own frames, keep loading and forward bits until count reached.
// - Inputs TTL until configured, then as programmed; some stay CMOS.
// - Pull-ups on until configured; afterwards per programmed option.
// - Readback option never, one-time or on-command.
// - Readback starts on trigger rising edge, uses mode pins and clock.
// - External clock drives readback; two dummy bits, then first frame.
// - Readback data bits are inverted.
// - Readback frames carry one start and one stop bit.
// - Readback ends only after every frame; pins then return to normal.
// - Readback inserts storage element state into unused bit positions.
// - Stream: high preamble, four-bit code, 24-bit length count stored.
// - Counter cleared at start counts clocks; done at length and frames.
// - Mode pins sampled at start choose the loading method.
`timescale 1ns/1ps
`include "fcml_loader_map.vh"

module fcml_loader (
  // Clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // Control and options
  input  wire        start_i,
  input  wire [2:0]  mode_i,
  input  wire        cmos_opt_i,
  input  wire        pullup_opt_i,
  input  wire [1:0]  readback_opt_i,
  input  wire [3:0]  state_bits_i,
  // Serial data and configuration clock pin
  input  wire        din_i,
  input  wire        config_clock_i,
  output reg         config_clock_o,
  output reg         config_clock_oe_o,
  output reg         dout_o,
  // Parallel memory port
  output reg  [15:0] addr_o,
  output reg         read_clock_o,
  input  wire [7:0]  data_i,
  // Peripheral port
  input  wire        write_strobe_n_i,
  input  wire        chip_select_a_n_i,
  input  wire        chip_select_b_n_i,
  input  wire        chip_select_c_high_i,
  output reg         ready_o,
  // Readback
  input  wire        readback_trigger_pin_i,
  output reg         readback_data_pin_o,
  output reg         readback_data_oe_o,
  // Status and pad control
  output reg         done_o,
  output reg         io_cmos_o,
  output reg         fixed_cmos_o,
  output reg         io_pullup_o
);

  localparam ST_IDLE = 4'h1;
  localparam ST_LOAD = 4'h2;
  localparam ST_DONE = 4'h4;
  localparam ST_RB   = 4'h8;
  localparam PH_PRE  = 4'h1;
  localparam PH_LEN  = 4'h2;
  localparam PH_FRM  = 4'h4;
  localparam PH_PASS = 4'h8;

  // Two-flop synchronisers for all pin inputs
  wire [17:0] raw = {mode_i, readback_trigger_pin_i, chip_select_c_high_i,
                     chip_select_b_n_i, chip_select_a_n_i, write_strobe_n_i,
                     config_clock_i, din_i, data_i};
  reg  [17:0] s1_q;
  reg  [17:0] s2_q;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= 18'h0;
      s2_q <= 18'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire [7:0] d_s    = s2_q[7:0];
  wire       din_s  = s2_q[8];
  wire       ck_s   = s2_q[9];
  wire       qual   = ~s2_q[10] & ~s2_q[11] & ~s2_q[12] & s2_q[13];
  wire       trig_s = s2_q[14];
  wire [2:0] mode_s = s2_q[17:15];

  reg  [3:0]  st_q;
  reg  [3:0]  ph_q;
  reg  [2:0]  mode_q;
  reg  [3:0]  div_q;
  reg         burst_q;
  reg  [3:0]  pcnt_q;
  reg  [7:0]  pbyte_q;
  reg  [7:0]  pbuf_q;
  reg  [3:0]  sr_q;
  reg  [4:0]  lcnt_q;
  reg  [23:0] len_q;
  reg  [23:0] cnt_q;
  reg         infrm_q;
  reg  [2:0]  fcnt_q;
  reg  [1:0]  frame_q;
  reg  [7:0]  fword_q;
  reg         dout_pend_q;
  reg         ck_d_q;
  reg         qual_d_q;
  reg         trig_d_q;
  reg  [1:0]  rb_dum_q;
  reg  [3:0]  rb_k_q;
  reg  [1:0]  rb_f_q;
  reg         rb_end_q;
  reg         rb_used_q;
  reg  [`FCML_FRAME_BITS-1:0] mem [0:`FCML_FRAMES-1];

  wire is_slv  = (mode_q == `FCML_MODE_SLV);
  wire is_per  = (mode_q == `FCML_MODE_PER);
  wire is_phi  = (mode_q == `FCML_MODE_PHI);
  wire is_par  = (mode_q == `FCML_MODE_PLO) | is_phi;
  wire ld      = (st_q == ST_LOAD);
  wire run     = ld & ~is_slv & (~is_per | burst_q);
  wire tick    = run & (div_q == `FCML_CONFIG_CLOCK_HALF_CYC - 4'h1);
  wire int_r   = tick & ~config_clock_o;
  wire int_f   = tick & config_clock_o;
  wire ext_r   = ck_s & ~ck_d_q;
  wire ext_f   = ~ck_s & ck_d_q;
  wire rise    = is_slv ? ext_r : int_r;
  wire fall    = is_slv ? ext_f : int_f;
  wire bit_evt = ld & rise;
  wire qrise   = qual & ~qual_d_q;
  wire trise   = trig_s & ~trig_d_q;
  wire rb_ok   = (readback_opt_i == `FCML_RB_CMD) |
                 ((readback_opt_i == `FCML_RB_ONCE) & ~rb_used_q);
  reg        b;
  wire [7:0] fword_n = {b, fword_q[7:1]};

  // Bit presented to the framer this clock
  always @* begin
    b = din_s;
    if (is_par) begin
      b = (pcnt_q[2:0] == 3'h0) ? d_s[0] : pbyte_q[pcnt_q[2:0]];
    end else if (is_per) begin
      b = pbuf_q[pcnt_q[2:0]];
    end
  end

  // Readback word with storage state in the last frame bit
  wire [7:0] rb_word = {state_bits_i[rb_f_q], mem[rb_f_q][6:0]};
  reg        rb_bit;
  always @* begin
    rb_bit = 1'b1;
    if (rb_dum_q == 2'h0) begin
      if (rb_k_q == 4'h0) begin
        rb_bit = 1'b0;
      end else if (rb_k_q == `FCML_RB_STOP_POS) begin
        rb_bit = 1'b1;
      end else begin
        rb_bit = ~rb_word[rb_k_q[2:0] - 3'h1];
      end
    end
  end

  always @(posedge clk_i) begin
    if (bit_evt & (ph_q == PH_FRM) & infrm_q &
        (fcnt_q == `FCML_FRAME_LAST)) begin
      mem[frame_q] <= fword_n;
    end
  end

  // Internal configuration clock divider
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_q          <= 4'h0;
      config_clock_o <= 1'b0;
    end else if (!run) begin
      div_q          <= 4'h0;
      config_clock_o <= 1'b0;
    end else if (tick) begin
      div_q          <= 4'h0;
      config_clock_o <= ~config_clock_o;
    end else begin
      div_q          <= div_q + 4'h1;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= ST_IDLE;
      ph_q <= PH_PRE;
      mode_q <= `FCML_MODE_SER;
      burst_q <= 1'b0;
      pcnt_q <= 4'h0;
      pbyte_q <= 8'h0;
      pbuf_q <= 8'h0;
      sr_q <= 4'hf;
      lcnt_q <= 5'h0;
      len_q <= 24'h0;
      cnt_q <= 24'h0;
      infrm_q <= 1'b0;
      fcnt_q <= 3'h0;
      frame_q <= 2'h0;
      fword_q <= 8'h0;
      dout_pend_q <= 1'b1;
      ck_d_q <= 1'b0;
      qual_d_q <= 1'b0;
      trig_d_q <= 1'b0;
      rb_dum_q <= 2'h0;
      rb_k_q <= 4'h0;
      rb_f_q <= 2'h0;
      rb_end_q <= 1'b0;
      rb_used_q <= 1'b0;
      config_clock_oe_o <= 1'b0;
      dout_o <= 1'b1;
      addr_o <= 16'h0;
      read_clock_o <= 1'b0;
      ready_o <= 1'b0;
      readback_data_pin_o <= 1'b1;
      readback_data_oe_o <= 1'b0;
      done_o <= 1'b0;
      io_cmos_o <= 1'b0;
      fixed_cmos_o <= 1'b1;
      io_pullup_o <= 1'b1;
    end else begin
      ck_d_q <= ck_s;
      qual_d_q <= qual;
      trig_d_q <= trig_s;
      read_clock_o <= 1'b0;
      config_clock_oe_o <= ld & ~is_slv;
      done_o <= (st_q == ST_DONE) | (st_q == ST_RB);
      io_cmos_o <= ((st_q == ST_DONE) | (st_q == ST_RB)) & cmos_opt_i;
      fixed_cmos_o <= 1'b1;
      io_pullup_o <= ~((st_q == ST_DONE) | (st_q == ST_RB)) |
                     pullup_opt_i;
      if (ld & fall) begin
        dout_o <= dout_pend_q;
      end
      case (st_q)
        ST_IDLE: begin
          if (start_i) begin
            st_q <= ST_LOAD;
            mode_q <= mode_s;
            ph_q <= PH_PRE;
            sr_q <= 4'hf;
            cnt_q <= 24'h0;
            frame_q <= 2'h0;
            infrm_q <= 1'b0;
            pcnt_q <= 4'h0;
            burst_q <= 1'b0;
            ready_o <= (mode_s == `FCML_MODE_PER);
            addr_o <= (mode_s == `FCML_MODE_PHI) ? `FCML_ADDR_HI_START
                                                 : `FCML_ADDR_LO_START;
          end
        end
        ST_LOAD: begin
          if (is_per & qrise & ready_o) begin
            pbuf_q <= d_s;
            ready_o <= 1'b0;
            burst_q <= 1'b1;
            pcnt_q <= 4'h0;
          end
          if (is_per & burst_q & fall & (pcnt_q == `FCML_BYTE_BITS)) begin
            burst_q <= 1'b0;
            ready_o <= 1'b1;
            pcnt_q <= 4'h0;
          end
          if (bit_evt) begin
            cnt_q <= cnt_q + 24'h1;
            if (is_per) begin
              pcnt_q <= pcnt_q + 4'h1;
            end else if (is_par) begin
              pcnt_q <= {1'b0, pcnt_q[2:0] + 3'h1};
              if (pcnt_q[2:0] == 3'h0) begin
                pbyte_q <= d_s;
                read_clock_o <= 1'b1;
                addr_o <= is_phi ? addr_o - 16'h1 : addr_o + 16'h1;
              end
            end
            case (ph_q)
              PH_PRE: begin
                dout_pend_q <= b;
                sr_q <= {sr_q[2:0], b};
                if ({sr_q[2:0], b} == `FCML_PRE_CODE) begin
                  ph_q <= PH_LEN;
                  lcnt_q <= 5'h0;
                end
              end
              PH_LEN: begin
                dout_pend_q <= b;
                len_q <= {len_q[22:0], b};
                lcnt_q <= lcnt_q + 5'h1;
                if (lcnt_q == `FCML_LEN_LAST) begin
                  ph_q <= PH_FRM;
                end
              end
              PH_FRM: begin
                dout_pend_q <= 1'b1;
                if (!infrm_q) begin
                  infrm_q <= ~b;
                  fcnt_q <= 3'h0;
                end else begin
                  fword_q <= fword_n;
                  fcnt_q <= fcnt_q + 3'h1;
                  if (fcnt_q == `FCML_FRAME_LAST) begin
                    infrm_q <= 1'b0;
                    frame_q <= frame_q + 2'h1;
                    if (frame_q == `FCML_FRAME_IDX_MAX) begin
                      ph_q <= PH_PASS;
                    end
                  end
                end
              end
              PH_PASS: begin
                dout_pend_q <= b;
              end
              default: ph_q <= PH_PRE;
            endcase
          end
          if ((ph_q == PH_PASS) & (cnt_q >= len_q) & ~config_clock_o) begin
            st_q <= ST_DONE;
            ready_o <= 1'b0;
            burst_q <= 1'b0;
          end
        end
        ST_DONE: begin
          if (trise & rb_ok) begin
            st_q <= ST_RB;
            readback_data_pin_o <= 1'b1;
            readback_data_oe_o <= 1'b1;
            rb_dum_q <= `FCML_RB_DUMMY_LEFT;
            rb_k_q <= 4'h0;
            rb_f_q <= 2'h0;
            rb_end_q <= 1'b0;
          end
        end
        ST_RB: begin
          if (ext_f) begin
            if (rb_end_q) begin
              st_q <= ST_DONE;
              readback_data_oe_o <= 1'b0;
              readback_data_pin_o <= 1'b1;
              rb_used_q <= 1'b1;
            end else begin
              readback_data_pin_o <= rb_bit;
              if (rb_dum_q != 2'h0) begin
                rb_dum_q <= rb_dum_q - 2'h1;
              end else if (rb_k_q == `FCML_RB_STOP_POS) begin
                rb_k_q <= 4'h0;
                rb_f_q <= rb_f_q + 2'h1;
                rb_end_q <= (rb_f_q == `FCML_FRAME_IDX_MAX);
              end else begin
                rb_k_q <= rb_k_q + 4'h1;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: src/fcml_loader_map.vh */
// Constants for the configuration mode loader
`ifndef FCML_LOADER_MAP_VH
`define FCML_LOADER_MAP_VH

// Mode pin codes, sampled at start of configuration
`define FCML_MODE_SER      3'h0
`define FCML_MODE_PLO      3'h4
`define FCML_MODE_PHI      3'h6
`define FCML_MODE_PER      3'h5
`define FCML_MODE_SLV      3'h7

// Parallel address start values
`define FCML_ADDR_LO_START 16'h0000
`define FCML_ADDR_HI_START 16'hffff

// Stream header
`define FCML_PRE_CODE      4'h2
`define FCML_LEN_LAST      5'h17

// Configuration memory shape
`define FCML_FRAME_BITS    8
`define FCML_FRAME_LAST    3'h7
`define FCML_FRAMES        4
`define FCML_FRAME_IDX_MAX 2'h3
`define FCML_BYTE_BITS     4'h8

// Readback framing
`define FCML_RB_STOP_POS   4'h9
`define FCML_RB_DUMMY_LEFT 2'h1
`define FCML_RB_NEVER      2'h0
`define FCML_RB_ONCE       2'h1
`define FCML_RB_CMD        2'h2

// Internal configuration clock half period
`define FCML_CLK_NS        40
`define FCML_CONFIG_CLOCK_HALF_NS  320
`define FCML_CONFIG_CLOCK_HALF_CYC (`FCML_CONFIG_CLOCK_HALF_NS / `FCML_CLK_NS)

`endif
